// ===== rtl/hts_link.sv
// Shared constants and the link-clock serialiser of the humidity and temperature readout.
package hts_pkg;
  // ==========================================================================
  // Timing.
  localparam int CLK_MHZ        = 250;            // Core clock rate.
  localparam int POR_TIME_US    = 20000;          // Power-up internal reset time.
  localparam int POR_CYC_DEF    = POR_TIME_US * CLK_MHZ;
  localparam int BIT_RATE_HZ    = 3000;           // Serial bit clock rate.
  localparam int LINK_PERIOD_NS = 15;             // Link clock period.
  localparam int HALF_BIT_NS    = 1_000_000_000 / (2 * BIT_RATE_HZ);
  localparam int HALF_BIT_CYC   = HALF_BIT_NS / LINK_PERIOD_NS;
  // ==========================================================================
  // Frame layout.
  localparam int FRM_W     = 32;                  // Whole frame width.
  localparam int FRM_MSB   = 31;                  // First bit on the line.
  localparam int FRM_T_LSB = 16;                  // Temperature word low bit.
  localparam int FRM_H_MSB = 15;                  // Humidity byte high bit.
  localparam int FRM_H_LSB = 8;                   // Humidity byte low bit.
  localparam int FRM_C_MSB = 7;                   // CRC byte high bit.
  localparam int DATA_BITS = 24;                  // Bits covered by the CRC.
  localparam logic [4:0]  LAST_BIT    = 5'h1f;    // Index of the last frame bit.
  localparam logic [15:0] TEMP_OFFSET = 16'h0190; // Forty degrees in tenths.
  localparam logic [7:0]  CRC_INIT    = 8'h00;    // CRC start value.
  localparam logic [7:0]  CRC_POLY    = 8'h31;    // Flips bits 4 and 5, sets bit 0.
  // ==========================================================================
  // State encodings.
  typedef enum logic [1:0] {ST_POR = 2'h0, ST_MEAS = 2'h1, ST_SEND = 2'h3, ST_SLEEP = 2'h2} hts_state_e;
  typedef enum logic {LK_IDLE = 1'h0, LK_SHIFT = 1'h1} hts_link_e;
  // ==========================================================================
  // One CRC step for one incoming bit.
  function automatic logic [7:0] hts_crc_step(input logic [7:0] crc, input logic din);
    if (din == crc[7])
      return {crc[6:0], 1'b0};
    else
      return {crc[6:0], 1'b0} ^ CRC_POLY;
  endfunction : hts_crc_step
endpackage : hts_pkg

`timescale 1ns/1ps
`default_nettype none
module hts_link
  import hts_pkg::*;
#(
  parameter int HALF_BIT = HALF_BIT_CYC // Half bit-clock period in link clock cycles.
)(
  input  wire logic             link_clk,
  input  wire logic             rst_lvl,
  input  wire logic             ce_lvl,
  input  wire logic             en_lvl,
  input  wire logic             req_tgl,
  input  wire logic [FRM_W-1:0] frame_in,
  output logic                  ack_tgl,
  output logic                  bclk,
  output logic                  dout
);
  // ==========================================================================
  // Synchronisers for the levels coming from the core domain.
  logic [3:0]  sync1;    // First stage, read only by the second.
  logic [3:0]  sync2;    // Second stage.
  logic        lrst;     // Link domain reset.
  logic        lce;      // Link domain clock enable.
  logic        en_s;     // Transfer allowed.
  logic        req_s;    // Request toggle.
  logic        req_seen; // Last request toggle handled.
  hts_link_e   lk_state; // Serialiser state.
  logic [FRM_W-1:0] shreg; // Bits still to send, next one at the top.
  logic [4:0]  bit_cnt;  // Bit index in the frame.
  logic [15:0] cnt;      // Half-period counter.
  logic        new_req;  // A request toggle waits.
  logic        half_end; // Half period has elapsed.
  assign {lrst, lce, en_s, req_s} = sync2;
  assign new_req  = req_s ^ req_seen;
  assign half_end = (cnt == 16'(HALF_BIT - 1));
  // Two flip-flops per crossing level.
  always_ff @(posedge link_clk)
  begin
    sync1 <= {rst_lvl, ce_lvl, en_lvl, req_tgl};
    sync2 <= sync1;
  end
  // ==========================================================================
  // Serialiser: data changes while the bit clock is low, stays during high.
  always_ff @(posedge link_clk)
  begin
    if (lrst)
    begin
      lk_state <= LK_IDLE;
      req_seen <= 1'b0;
      ack_tgl  <= 1'b0;
      bclk     <= 1'b0;
      dout     <= 1'b0;
      shreg    <= '0;
      bit_cnt  <= '0;
      cnt      <= '0;
    end
    else if (lce)
    begin
      unique case (lk_state)
        LK_IDLE:
        begin
          // A request is taken; the frame has been stable since the toggle.
          if (new_req)
          begin
            req_seen <= req_s;
            if (en_s)
            begin
              shreg    <= frame_in;
              dout     <= frame_in[FRM_MSB];
              bclk     <= 1'b0;
              cnt      <= '0;
              bit_cnt  <= '0;
              lk_state <= LK_SHIFT;
            end
            else
            begin
              // Withdrawn before start: answer at once.
              ack_tgl <= ~ack_tgl;
            end
          end
        end
        LK_SHIFT:
        begin
          if (!en_s)
          begin
            // Select released: stop immediately and park.
            bclk     <= 1'b0;
            dout     <= 1'b0;
            ack_tgl  <= ~ack_tgl;
            lk_state <= LK_IDLE;
          end
          else if (half_end)
          begin
            cnt <= '0;
            if (!bclk)
            begin
              bclk <= 1'b1;
            end
            else
            begin
              bclk <= 1'b0;
              if (bit_cnt == LAST_BIT)
              begin
                dout     <= 1'b0;
                ack_tgl  <= ~ack_tgl;
                lk_state <= LK_IDLE;
              end
              else
              begin
                shreg   <= shreg << 1;
                dout    <= shreg[FRM_MSB-1];
                bit_cnt <= bit_cnt + 5'h1;
              end
            end
          end
          else
          begin
            cnt <= cnt + 16'h1;
          end
        end
      endcase
    end
  end
  // ==========================================================================
  // Checks on the link side.
  default clocking @(posedge link_clk); endclocking
  default disable iff (lrst);
  sequence s_load;
    lce && lk_state == LK_IDLE && new_req && en_s;
  endsequence
  chk_park_idle: assert property (lk_state == LK_IDLE |-> !bclk && !dout)
    else $error("link idle but outputs not parked low");
  chk_msb_first: assert property (s_load |=> dout == $past(frame_in[FRM_MSB]))
    else $error("first bit is not the frame MSB");
  chk_data_hold: assert property ($changed(dout) |-> !bclk)
    else $error("data changed while bit clock high");
  chk_abort_park: assert property (lce && lk_state == LK_SHIFT && !en_s |=> lk_state == LK_IDLE && !bclk)
    else $error("transfer not aborted on release");
  chk_half_rate: assert property (lce && lk_state == LK_SHIFT && en_s && !half_end |=> $stable(bclk))
    else $error("bit clock toggled before half period");
endmodule : hts_link
`default_nettype wire

// ===== rtl/hts_readout.sv
// Core of the humidity and temperature readout: wake, measure, frame and hand to the link.
`timescale 1ns/1ps
`default_nettype none
module hts_readout
  import hts_pkg::*;
#(
  parameter int POR_CYCLES = POR_CYC_DEF, // Power-up wait in core clock cycles.
  parameter int HALF_BIT   = HALF_BIT_CYC // Half bit-clock period in link clock cycles.
)(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        ce,
  input  wire logic        link_clk,
  input  wire logic        sel_n,
  input  wire logic        sel_drv,
  input  wire logic        rst_pin_n,
  input  wire logic [15:0] temp_dc,
  input  wire logic [7:0]  hum_pct,
  input  wire logic        conv_done,
  output logic             conv_start,
  output logic             bit_clk,
  output logic             sensor_data_out
);
  // ==========================================================================
  // Declarations.
  localparam int POR_W = $clog2(POR_CYCLES + 1); // Power-up counter width.

  logic [2:0]       pin_s1;    // First pin stage, read by the second and by chk_undriven_sel.
  logic [2:0]       pin_s2;    // Second pin stage: reset pin, drive, select.
  logic             sel_low;   // Select asserted and actually driven.
  logic             pin_rst;   // Reset pin held low.
  logic             core_rst;  // Combined reset of the core.
  logic             rst_lvl;   // Registered reset level for the link domain.
  logic [POR_W-1:0] por_cnt;   // Power-up counter.
  logic             por_done;  // Power-up wait over.
  hts_state_e       state;     // Sequencer state.
  logic             meas_run;  // A conversion has been started.
  logic             issued;    // The current frame was handed over.
  logic             xfer_en;   // Link may transmit.
  logic             req;       // Request toggle to the link.
  logic             ack_tgl;   // Answer toggle from the link.
  logic             ack_s1;    // First answer stage.
  logic             ack_s2;    // Second answer stage.
  logic             pending;   // A request awaits its answer.
  logic             capture;   // Conversion result arrives now.
  logic [FRM_W-1:0] frame;     // Stored frame, stable while pending.
  logic [15:0]      next_temp; // Coded temperature word.
  logic [7:0]       next_crc;  // CRC over the new measurement.

  assign sel_low  = pin_s2[1] & ~pin_s2[0];
  assign pin_rst  = ~pin_s2[2];
  assign core_rst = srst | pin_rst;
  assign por_done = (por_cnt == POR_W'(POR_CYCLES - 1));
  assign pending  = req ^ ack_s2;
  assign capture  = ce && state == ST_MEAS && meas_run && conv_done;

  // ==========================================================================
  // Pin synchronisers.

  // Pins are asynchronous to the core clock and pass two flip-flops.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      // Idle levels: reset pin released, line driven, select high.
      pin_s1 <= 3'h7;
      pin_s2 <= 3'h7;
    end
    else if (ce)
    begin
      pin_s1 <= {rst_pin_n, sel_drv, sel_n};
      pin_s2 <= pin_s1;
    end
  end

  // The answer toggle from the link domain passes two flip-flops.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
    end
    else if (ce)
    begin
      ack_s1 <= ack_tgl;
      ack_s2 <= ack_s1;
    end
  end

  // Reset level handed to the link domain, synchronised there.
  always_ff @(posedge clk)
  begin
    if (srst)
      rst_lvl <= 1'b1;
    else if (ce)
      rst_lvl <= pin_rst;
  end

  // ==========================================================================
  // Power-up wait.

  // Counts the internal reset time after power or a reset pin pulse.
  always_ff @(posedge clk)
  begin
    if (core_rst)
      por_cnt <= '0;
    else if (ce && state == ST_POR && !por_done)
      por_cnt <= por_cnt + POR_W'(1);
  end

  // ==========================================================================
  // Sequencer.

  // Drives the measure and send cycle from the select line.
  always_ff @(posedge clk)
  begin
    if (core_rst)
    begin
      state      <= ST_POR;
      meas_run   <= 1'b0;
      issued     <= 1'b0;
      xfer_en    <= 1'b0;
      req        <= 1'b0;
      conv_start <= 1'b0;
    end
    else if (ce)
    begin
      conv_start <= 1'b0;
      unique case (state)
        // Wait out the internal reset, then measure once on our own.
        ST_POR:
        begin
          if (por_done)
          begin
            state    <= ST_MEAS;
            meas_run <= 1'b0;
          end
        end
        // Start a conversion once the link has settled, then decide.
        ST_MEAS:
        begin
          if (!meas_run && !pending)
          begin
            conv_start <= 1'b1;
            meas_run   <= 1'b1;
          end
          else if (capture)
          begin
            meas_run <= 1'b0;
            if (sel_low)
            begin
              // Still selected: send the fresh result.
              state   <= ST_SEND;
              xfer_en <= 1'b1;
              issued  <= 1'b0;
            end
            else
            begin
              // Released: the result waits for the next read.
              state <= ST_SLEEP;
            end
          end
        end
        // Hand the frame over and wait for the answer.
        ST_SEND:
        begin
          if (!sel_low)
          begin
            // Release aborts the transfer; one more measurement follows.
            xfer_en  <= 1'b0;
            state    <= ST_MEAS;
            meas_run <= 1'b0;
          end
          else if (!issued && !pending)
          begin
            req    <= ~req;
            issued <= 1'b1;
          end
          else if (issued && !pending)
          begin
            // Frame out: start a new conversion.
            xfer_en  <= 1'b0;
            state    <= ST_MEAS;
            meas_run <= 1'b0;
          end
        end
        // Asleep until the select line is asserted.
        ST_SLEEP:
        begin
          if (sel_low && !pending)
          begin
            state   <= ST_SEND;
            xfer_en <= 1'b1;
            issued  <= 1'b0;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Frame building.

  // Scale is done by the front end in tenths; the word adds the forty degree offset.
  assign next_temp = 16'(temp_dc + TEMP_OFFSET);

  // CRC over the three data bytes in line order, starting from zero.
  always_comb
  begin
    logic [DATA_BITS-1:0] data;
    data     = {next_temp, hum_pct};
    next_crc = CRC_INIT;
    for (int i = DATA_BITS - 1; i >= 0; i--)
      next_crc = hts_crc_step(next_crc, data[i]);
  end

  // The frame is only replaced while no request is open.
  always_ff @(posedge clk)
  begin
    if (srst)
      frame <= '0;
    else if (capture)
      frame <= {next_temp, hum_pct, next_crc};
  end

  // ==========================================================================
  // Link side.
  hts_link #(
    .HALF_BIT (HALF_BIT)
  ) u_link (
    .link_clk (link_clk),
    .rst_lvl  (rst_lvl),
    .ce_lvl   (ce),
    .en_lvl   (xfer_en),
    .req_tgl  (req),
    .frame_in (frame),
    .ack_tgl  (ack_tgl),
    .bclk     (bit_clk),
    .dout     (sensor_data_out)
  );

  // ==========================================================================
  // Checks on the core side.
  default clocking @(posedge clk); endclocking
  default disable iff (core_rst);

  sequence s_boot_end;
    ce && state == ST_POR && por_done;
  endsequence
  sequence s_meas_start;
    state == ST_MEAS ##1 conv_start;
  endsequence

  chk_por_quiet: assert property (state == ST_POR |-> !conv_start && !xfer_en)
    else $error("activity during power-up wait");
  chk_boot_meas: assert property (s_boot_end ##1 ce |-> s_meas_start)
    else $error("no measurement after power-up wait");
  chk_wake_send: assert property (ce && state == ST_SLEEP && sel_low && !pending |=> state == ST_SEND && xfer_en)
    else $error("select did not wake a transfer");
  chk_send_meas: assert property (ce && state == ST_SEND && sel_low && issued && !pending |=> state == ST_MEAS)
    else $error("no conversion after frame sent");
  chk_repeat_cycle: assert property (capture && sel_low |=> state == ST_SEND ##1 (!ce || pending || issued))
    else $error("held select did not repeat the cycle");
  chk_abort_send: assert property (ce && state == ST_SEND && !sel_low |=> state == ST_MEAS && !xfer_en)
    else $error("release did not abort and remeasure");
  chk_sleep_after: assert property (capture && !sel_low |=> state == ST_SLEEP)
    else $error("no sleep after extra measurement");
  chk_undriven_sel: assert property (ce && !pin_s1[1] |=> !sel_low)
    else $error("undriven select seen as asserted");
  chk_temp_code: assert property (capture |=> frame[FRM_MSB:FRM_T_LSB] == $past(temp_dc) + TEMP_OFFSET)
    else $error("temperature word not offset");
  chk_hum_byte: assert property (capture |=> frame[FRM_H_MSB:FRM_H_LSB] == $past(hum_pct))
    else $error("humidity byte altered");
endmodule : hts_readout
`default_nettype wire

// ===== bench/hts_rx_model.sv
// Host receiver model that samples the serial frames of the readout.
`timescale 1ns/1ps
`default_nettype none
module hts_rx_model
(
  input  wire logic   bit_clk,          // Bit clock made by the device.
  input  wire logic   sensor_data_out,  // Serial data from the device.
  input  wire logic   sel_n,            // Select line as the host drives it.
  output logic [31:0] frame,            // Last complete frame.
  output int          frame_cnt,        // Complete frames received.
  output int          bit_cnt,          // Bits of the frame in progress.
  output longint      per_ns,           // Last bit clock period in ns.
  output logic        crc_ok            // Received check byte matches.
);
  // ==========================================================================
  // Frame check.
  logic [31:0] shreg;   // Incoming bits, oldest at the top.
  longint      t_rise;  // Time of the previous rising bit clock edge.

  // Bitwise CRC over the 24 data bits, most significant first.
  function automatic logic [7:0] crc8(input logic [23:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 23; i >= 0; i--)
    begin
      if (d[i] == c[7])
        c = {c[6:0], 1'b0};
      else
        c = {c[6:0], 1'b0} ^ 8'h31;
    end
    return c;
  endfunction : crc8

  // ==========================================================================
  // Sampling.
  initial
  begin
    frame_cnt = 0;
    bit_cnt   = 0;
    t_rise    = 0;
    per_ns    = 0;
    crc_ok    = 1'b0;
    frame     = 32'h0000_0000;
    shreg     = 32'h0000_0000;
  end

  // Data is taken at each rising bit clock edge; 32 bits make one frame.
  // A deselected host takes no bits, even during the device's abort latency.
  always @(posedge bit_clk)
  begin
    per_ns = $time - t_rise;
    t_rise = $time;
    if (sel_n === 1'b0)
    begin
      shreg  = {shreg[30:0], sensor_data_out};
      bit_cnt++;
      if (bit_cnt == 32)
      begin
        frame   = shreg;
        crc_ok  = (crc8(shreg[31:8]) === shreg[7:0]);
        bit_cnt = 0;
        frame_cnt++;
      end
    end
  end

  // Releasing select throws away a partial frame.
  always @(posedge sel_n)
    bit_cnt = 0;
endmodule : hts_rx_model
`default_nettype wire

// ===== bench/hts_readout_tb.sv
// Self-checking testbench of the humidity and temperature readout.
`timescale 1ns/1ps
`default_nettype none
module hts_readout_tb;
  import hts_pkg::*;
  // ==========================================================================
  // Signals.
  localparam int POR_SIM  = 50;  // Shortened power-up wait.
  localparam int HALF_SIM = 4;   // Shortened half bit period.
  localparam int FE_LAT   = 20;  // Front-end conversion latency.
  logic        clk, srst, ce, link_clk, sel_n, sel_drv, rst_pin_n;
  logic        conv_done, conv_start, bit_clk, sensor_data_out;
  logic [15:0] temp_dc;          // Temperature handed to the device.
  logic [7:0]  hum_pct;          // Humidity handed to the device.
  logic [31:0] rx_frame;         // Frame seen by the receiver.
  logic        rx_crc_ok;        // Receiver check result.
  int          rx_frames;        // Frames seen by the receiver.
  int          rx_bits;          // Bits of the frame in progress.
  longint      per_ns;           // Measured bit clock period.
  int          n_conv, fe_cnt;   // Conversions started, latency count.
  int          n_errors, num_checks;

  hts_readout #(.POR_CYCLES(POR_SIM), .HALF_BIT(HALF_SIM)) u_dut
  (
    .clk(clk), .srst(srst), .ce(ce), .link_clk(link_clk), .sel_n(sel_n),
    .sel_drv(sel_drv), .rst_pin_n(rst_pin_n), .temp_dc(temp_dc), .hum_pct(hum_pct),
    .conv_done(conv_done), .conv_start(conv_start), .bit_clk(bit_clk),
    .sensor_data_out(sensor_data_out)
  );
  hts_rx_model u_rx
  (
    .bit_clk(bit_clk), .sensor_data_out(sensor_data_out), .sel_n(sel_n), .frame(rx_frame),
    .frame_cnt(rx_frames), .bit_cnt(rx_bits), .per_ns(per_ns), .crc_ok(rx_crc_ok)
  );

  // Core clock at 250 MHz and an unrelated 15 ns link clock.
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial
  begin
    link_clk = 1'b0;
    #3.3;
    forever #7.5 link_clk = ~link_clk;
  end

  // Front end: answers each conversion start after a fixed latency.
  always @(negedge clk)
  begin
    conv_done = 1'b0;
    if (conv_start === 1'b1)
    begin
      n_conv++;
      fe_cnt = FE_LAT;
    end
    else if (fe_cnt > 0)
    begin
      fe_cnt--;
      conv_done = (fe_cnt == 0);
    end
  end

  // ==========================================================================
  // Common tasks.
  task automatic stop_test();
    $display("Checks made: %0d, mismatches: %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test

  // Counts one comparison and reports a mismatch at once.
  task automatic check(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1)
    begin
      n_errors++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask : check

  // Waits, bounded, until a counter reaches a target.
  task automatic wait_cnt(ref int c, input int target);
    for (int i = 0; i < 5000 && c < target; i++)
      @(negedge clk);
    if (c < target)
    begin
      n_errors++;
      $display("Error at %0t: wait ran out", $time);
      stop_test();
    end
  endtask : wait_cnt

  // Expected frame: offset temperature, humidity as is, then the check byte.
  function automatic logic [31:0] exp_frame(input logic [15:0] t, input logic [7:0] h);
    logic [15:0] code;
    code = t + 16'h0190;
    return {code, h, u_rx.crc8({code, h})};
  endfunction : exp_frame

  // ==========================================================================
  // Scenarios.
  // Select low from power-up: the first measurement goes out by itself.
  task automatic t_power_up();
    wait_cnt(rx_frames, 1);
    check(rx_frame === exp_frame(16'h00fa, 8'h51) && n_conv == 1, "first frame");
    check(rx_crc_ok === 1'b1, "first check byte");
    check(per_ns == 2 * HALF_SIM * 15, "bit clock period");
    for (int i = 0; i < 100 && bit_clk !== 1'b0; i++)
      @(negedge clk);
    check(bit_clk === 1'b0 && sensor_data_out === 1'b0, "lines not parked low");
  endtask : t_power_up

  // Select held low: a fresh conversion and frame follow; coldest code.
  task automatic t_repeat();
    temp_dc = 16'hfe70;
    hum_pct = 8'h64;
    wait_cnt(rx_frames, 2);
    check(rx_frame === exp_frame(16'hfe70, 8'h64) && rx_crc_ok === 1'b1, "repeat frame");
    check(n_conv == 2, "conversion count");
  endtask : t_repeat

  // Select released mid-frame: lines drop, one more conversion, then quiet.
  task automatic t_abort();
    int f, c;
    f = rx_frames;
    wait_cnt(rx_bits, 8);
    temp_dc = 16'h01f4;
    hum_pct = 8'h2d;
    c       = n_conv;
    sel_n   = 1'b1;
    repeat (30) @(negedge clk);
    check(bit_clk === 1'b0 && sensor_data_out === 1'b0, "link busy after abort");
    wait_cnt(n_conv, c + 1);
    repeat (2000) @(negedge clk);
    check(rx_frames == f && n_conv == c + 1 && rx_bits == 0, "activity in sleep");
  endtask : t_abort

  // An undriven select line reads high and never wakes the device.
  task automatic t_pullup();
    int f, c;
    f       = rx_frames;
    c       = n_conv;
    sel_drv = 1'b0;
    sel_n   = 1'b0;
    repeat (1500) @(negedge clk);
    check(rx_frames == f && n_conv == c && bit_clk === 1'b0, "undriven select woke");
    sel_n   = 1'b1;
    sel_drv = 1'b1;
    repeat (5) @(negedge clk);
  endtask : t_pullup

  // Wake: the stored measurement goes out before a new conversion starts.
  task automatic t_wake();
    int f, c;
    f     = rx_frames;
    c     = n_conv;
    sel_n = 1'b0;
    wait_cnt(rx_frames, f + 1);
    check(rx_frame === exp_frame(16'h01f4, 8'h2d), "stored frame");
    check(n_conv == c, "conversion before send");
    wait_cnt(n_conv, c + 1);
  endtask : t_wake

  // Recovery by the reset pin: the wait restarts, one measurement goes out.
  task automatic t_recover();
    int f, c;
    sel_n = 1'b1;
    repeat (30) @(negedge clk);
    f         = rx_frames;
    rst_pin_n = 1'b0;
    temp_dc   = 16'h0000;
    hum_pct   = 8'h12;
    sel_n     = 1'b0;
    repeat (30) @(negedge clk);
    check(bit_clk === 1'b0 && sensor_data_out === 1'b0, "lines active in reset");
    c         = n_conv;
    rst_pin_n = 1'b1;
    wait_cnt(rx_frames, f + 1);
    check(rx_frame === exp_frame(16'h0000, 8'h12) && n_conv == c + 1, "frame after reset pin");
  endtask : t_recover

  // ==========================================================================
  // Main sequence; the reset pin stays high until the recovery scenario.
  initial
  begin
    srst       = 1'b1;
    ce         = 1'b1;
    sel_n      = 1'b0;
    sel_drv    = 1'b1;
    rst_pin_n  = 1'b1;
    conv_done  = 1'b0;
    temp_dc    = 16'h00fa;
    hum_pct    = 8'h51;
    n_conv     = 0;
    fe_cnt     = 0;
    n_errors   = 0;
    num_checks = 0;
    // Held long enough for the link domain to see the reset too.
    repeat (20) @(negedge clk);
    srst = 1'b0;
    t_power_up();
    t_repeat();
    t_abort();
    t_pullup();
    t_wake();
    t_recover();
    stop_test();
  end
endmodule : hts_readout_tb
`default_nettype wire
